/* hw/hbd_pkg.sv */
// Purpose: Shared constants for the H-bridge diagnostic serial port
// Assumes: Core clock 100 MHz, serial clock from the master
// Notes: Identity values are parameters of the top module
package hbd_pkg;
  localparam int unsigned HBD_CORE_MHZ = 100;
  localparam int unsigned HBD_FRAME_BITS = 16;
  localparam logic [4:0] HBD_FRAME_LEN = 5'h10;
  localparam logic [1:0] HBD_CHIP_ADDR = 2'h0;
  localparam logic [5:0] HBD_OP_IDENT = 6'h00;
  localparam logic [5:0] HBD_OP_REV = 6'h03;
  localparam logic [5:0] HBD_OP_FAULT = 6'h09;
  localparam logic [7:0] HBD_FAULT_RST = 8'hFF;
  localparam logic [7:0] HBD_UNUSED_DATA = 8'hFF;
  localparam logic [7:0] HBD_CHECK_PAT = 8'h2A;
  localparam int unsigned HBD_CHECK_FLAG_BIT = 0;
  localparam int unsigned HBD_CHECK_HIZ_BITS = 2;
  localparam int unsigned HBD_FLT_CLAMP_BIT = 4;
  localparam int unsigned HBD_FLT_DERATE_BIT = 5;
  localparam int unsigned HBD_FLT_HEAT_BIT = 6;
  localparam int unsigned HBD_FLT_ACTIVE_BIT = 7;
  localparam int unsigned HBD_FLT_OUT1_LSB = 0;
  localparam int unsigned HBD_FLT_OUT2_LSB = 2;
  // Minimum access time between frames, in ns
  localparam int unsigned HBD_ACCESS_NS = 8350;
  localparam int unsigned HBD_ACCESS_CYC =
    (HBD_ACCESS_NS * HBD_CORE_MHZ + 999) / 1000;
endpackage : hbd_pkg

/* hw/hbd_sync.sv */
// Purpose: Two-flop level synchroniser
// Assumes: Destination clock free running
// Notes: Reset value is a parameter
`timescale 1ns/1ps
`default_nettype none
module hbd_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic en,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end else if (en) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : hbd_sync
`default_nettype wire

/* hw/hbd_fault_bit.sv */
// Purpose: One sticky active-low fault flag
// Assumes: Event input already synchronised
// Notes: A fresh event beats the reload to idle
`timescale 1ns/1ps
`default_nettype none
module hbd_fault_bit (
  input wire logic clk,
  input wire logic rstN,
  input wire logic en,
  input wire logic reload,
  input wire logic evt,
  output logic flagN
);
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flagN <= 1'b1;
    end else if (en) begin
      if (evt) begin
        flagN <= 1'b0;
      end else if (reload) begin
        flagN <= 1'b1;
      end
    end
  end
endmodule : hbd_fault_bit
`default_nettype wire

/* hw/hbd_spi_diag.sv */
// Purpose: Serial diagnostic slave port of an H-bridge driver
// Assumes: sclk is the master's clock, active only in frames
// Notes: Frame decisions are made in the core domain at select rise
`timescale 1ns/1ps
`default_nettype none
module hbd_spi_diag
  import hbd_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5C, // Arbitrary value
  parameter logic [3:0] SOFTWARE_REV = 4'h0, // Arbitrary value
  parameter logic [3:0] MASK_REV = 4'h0, // Arbitrary value
  parameter int unsigned ACCESS_CYC = HBD_ACCESS_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic modeSelectSupply,
  input wire logic sclk,
  input wire logic selectN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEnN,
  input wire logic bridgeOn,
  input wire logic shutoffInput,
  input wire logic out1FaultCodeHi,
  input wire logic out1FaultCodeLo,
  input wire logic out2FaultCodeHi,
  input wire logic out2FaultCodeLo,
  input wire logic currentClampFlag,
  input wire logic thermalDerateFlag,
  input wire logic overheatFlag,
  output logic [7:0] faultStatus,
  output logic priorFrameError
);
  // Core-domain reset release
  logic rstMeta_q;
  logic rstN_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstN_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN_q <= rstMeta_q;
    end
  end

  // Link side: held in reset while select high or supply low
  wire portRstN = nrst & modeSelectSupply & ~selectN;

  // Frame context captured in core domain, stable during frame
  logic [7:0] txData_q;
  logic prevErr_q;

  logic [4:0] bitCnt_q;
  logic [7:0] opcode_field_q;
  logic addrOk_q;
  logic addrSeen_q;
  logic overflow_q;
  logic [2:0] dataIdx_q;

  // Falling edge: sample input and count pulses
  always_ff @(negedge sclk or negedge portRstN) begin
    if (!portRstN) begin
      bitCnt_q <= 5'h00;
      opcode_field_q <= 8'h00;
      overflow_q <= 1'b0;
    end else begin
      if (bitCnt_q == 5'h1F) begin
        overflow_q <= 1'b1;
      end else begin
        bitCnt_q <= bitCnt_q + 5'h01;
      end
      if (bitCnt_q > HBD_FRAME_LEN) begin
        overflow_q <= 1'b1;
      end
      if (bitCnt_q < 5'h08) begin
        opcode_field_q <= {opcode_field_q[6:0], serialIn};
      end
    end
  end

  // Address recognised after two sampled bits
  wire addrDone = (bitCnt_q >= 5'h02);
  wire addrMatch = (opcode_field_q[1:0] == HBD_CHIP_ADDR);

  // Rising edge: drive output
  logic outBit_q;
  logic outDrv_q;
  always_ff @(posedge sclk or negedge portRstN) begin
    if (!portRstN) begin
      outBit_q <= 1'b0;
      outDrv_q <= 1'b0;
      addrOk_q <= 1'b0;
      addrSeen_q <= 1'b0;
      dataIdx_q <= 3'h7;
    end else begin
      if (addrDone && !addrSeen_q) begin
        addrSeen_q <= 1'b1;
        addrOk_q <= addrMatch;
      end
      if (bitCnt_q < 5'h08) begin
        outDrv_q <= (bitCnt_q >= HBD_CHECK_HIZ_BITS[4:0])
                    && (addrSeen_q ? addrOk_q : addrMatch);
        if (bitCnt_q == 5'h07) begin
          outBit_q <= prevErr_q;
        end else begin
          outBit_q <= HBD_CHECK_PAT[3'h7 - bitCnt_q[2:0]];
        end
      end else if (bitCnt_q < HBD_FRAME_LEN) begin
        outDrv_q <= addrOk_q;
        outBit_q <= txData_q[dataIdx_q];
        dataIdx_q <= dataIdx_q - 3'h1;
      end else begin
        outDrv_q <= 1'b0;
      end
    end
  end

  wire drive = outDrv_q & portRstN & ~shutoffInput;

  // Pass frame results into the core domain
  logic [13:0] capMeta_q;
  logic [13:0] cap_q;
  logic [13:0] snap_q;
  logic selSync;
  logic selPrev_q;
  logic modeSync;
  logic modePrev_q;
  logic drvSync;

  hbd_sync #(.RST_VAL(1'b1)) uSelSync (
    .clk(core_clk), .rstN(rstN_q), .en(clkEn),
    .din(selectN), .dout(selSync)
  );
  hbd_sync #(.RST_VAL(1'b0)) uModeSync (
    .clk(core_clk), .rstN(rstN_q), .en(clkEn),
    .din(modeSelectSupply), .dout(modeSync)
  );
  hbd_sync #(.RST_VAL(1'b0)) uDrvSync (
    .clk(core_clk), .rstN(rstN_q), .en(clkEn),
    .din(drive), .dout(drvSync)
  );

  // Snapshot at select rise; link reset clears the live copy then
  always_ff @(posedge selectN or negedge nrst) begin
    if (!nrst) begin
      snap_q <= 14'h0000;
    end else begin
      snap_q <= {overflow_q, bitCnt_q, opcode_field_q};
    end
  end

  // Snapshot is quiet while select is high, so no handshake needed
  always_ff @(posedge core_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      capMeta_q <= 14'h0000;
      cap_q <= 14'h0000;
    end else if (clkEn) begin
      capMeta_q <= snap_q;
      cap_q <= capMeta_q;
    end
  end

  logic [7:0] frameInstr;
  logic [4:0] frameCnt;
  logic frameOvf;
  assign frameOvf = cap_q[13];
  assign frameCnt = cap_q[12:8];
  assign frameInstr = cap_q[7:0];

  // Select rise ends the frame
  wire selRise = selSync & ~selPrev_q;
  wire modeRise = modeSync & ~modePrev_q;
  wire selFall = ~selSync & selPrev_q;

  // Access time counter since last frame end
  logic [$clog2(ACCESS_CYC + 1)-1:0] gapCnt_q;
  logic busy;
  assign busy = (gapCnt_q != '0);

  logic supplyRst_q;
  logic extraPrev_q;
  logic earlyHit_q;

  wire [5:0] opcode = frameInstr[5:0];
  wire frameAddrOk = (frameInstr[7:6] == HBD_CHIP_ADDR);
  wire opIdent = (opcode == HBD_OP_IDENT);
  wire opRev = (opcode == HBD_OP_REV);
  wire opFault = (opcode == HBD_OP_FAULT);
  wire opUnused = ~(opIdent | opRev | opFault);
  wire cntBad = frameOvf || (frameCnt != HBD_FRAME_LEN);
  wire cntLong = frameOvf || (frameCnt > HBD_FRAME_LEN);
  // Access time runs from one frame's end to the next frame's start
  wire frameBad = opUnused | earlyHit_q | extraPrev_q | supplyRst_q
                  | cntBad;
  wire goodFault = selRise & frameAddrOk & opFault & ~frameBad;

  // Live fault inputs, brought into core domain
  logic [7:0] liveRaw;
  logic [7:0] liveSync;
  assign liveRaw = {bridgeOn & ~shutoffInput, overheatFlag,
                    thermalDerateFlag, currentClampFlag,
                    out2FaultCodeHi, out2FaultCodeLo,
                    out1FaultCodeHi, out1FaultCodeLo};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gLive
      hbd_sync #(.RST_VAL(1'b0)) uLive (
        .clk(core_clk), .rstN(rstN_q), .en(clkEn),
        .din(liveRaw[gi]), .dout(liveSync[gi])
      );
    end
  endgenerate

  // Sticky active-low flags; reload on good fault read or on modeSelectSupply rise
  wire reloadFlags = goodFault | modeRise;
  logic clampN;
  logic derateN;
  logic heatN;
  hbd_fault_bit uClamp (
    .clk(core_clk), .rstN(rstN_q), .en(clkEn), .reload(reloadFlags),
    .evt(liveSync[HBD_FLT_CLAMP_BIT]), .flagN(clampN)
  );
  hbd_fault_bit uDerate (
    .clk(core_clk), .rstN(rstN_q), .en(clkEn), .reload(reloadFlags),
    .evt(liveSync[HBD_FLT_DERATE_BIT]), .flagN(derateN)
  );
  hbd_fault_bit uHeat (
    .clk(core_clk), .rstN(rstN_q), .en(clkEn), .reload(reloadFlags),
    .evt(liveSync[HBD_FLT_HEAT_BIT]), .flagN(heatN)
  );

  // Output codes: held until reload, new faults captured at reload
  logic [1:0] out1Code_q;
  logic [1:0] out2Code_q;
  logic [7:0] faultView;
  assign faultView = {liveSync[HBD_FLT_ACTIVE_BIT], heatN, derateN,
                      clampN, out2Code_q, out1Code_q};

  always_ff @(posedge core_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      selPrev_q <= 1'b1;
      modePrev_q <= 1'b0;
      gapCnt_q <= '0;
      supplyRst_q <= 1'b1;
      extraPrev_q <= 1'b0;
      earlyHit_q <= 1'b0;
      prevErr_q <= 1'b1;
      txData_q <= HBD_FAULT_RST;
      out1Code_q <= HBD_FAULT_RST[1:0];
      out2Code_q <= HBD_FAULT_RST[3:2];
      faultStatus <= HBD_FAULT_RST;
      priorFrameError <= 1'b1;
    end else if (clkEn) begin
      selPrev_q <= selSync;
      modePrev_q <= modeSync;
      if (!modeSync) begin
        supplyRst_q <= 1'b1;
        prevErr_q <= 1'b1;
        priorFrameError <= 1'b1;
      end
      if (selRise) begin
        earlyHit_q <= 1'b0;
      end
      if (selFall && busy) begin
        earlyHit_q <= 1'b1;
      end
      if (reloadFlags) begin
        out1Code_q <= liveSync[1:0];
        out2Code_q <= liveSync[3:2];
      end
      faultStatus <= faultView;
      if (busy) begin
        gapCnt_q <= gapCnt_q - ($clog2(ACCESS_CYC + 1))'(1);
      end
      if (selRise && frameAddrOk) begin
        gapCnt_q <= ($clog2(ACCESS_CYC + 1))'(ACCESS_CYC);
        prevErr_q <= frameBad;
        priorFrameError <= frameBad;
        extraPrev_q <= cntLong;
        supplyRst_q <= ~modeSync;
      end
      // Preload next reply while select is high
      if (selSync) begin
        if (opUnused) begin
          txData_q <= HBD_UNUSED_DATA;
        end else if (opIdent) begin
          txData_q <= DEVICE_ID;
        end else if (opRev) begin
          txData_q <= {SOFTWARE_REV, MASK_REV};
        end else begin
          txData_q <= faultView;
        end
      end
    end
  end

  // Output pins; enable low means driving
  always_ff @(posedge core_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      serialOut <= 1'b0;
      serialOutEnN <= 1'b1;
    end else if (clkEn) begin
      serialOut <= outBit_q;
      serialOutEnN <= ~drvSync;
    end
  end
endmodule : hbd_spi_diag
`default_nettype wire

/* test/hbd_spi_diag_sva.sv */
// Purpose: Port checks for hbd_spi_diag
// Assumes: One domain, core_clk
// Notes: Bounds allow for the input synchronisers
`timescale 1ns/1ps
`default_nettype none
module hbd_spi_diag_sva (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic modeSelectSupply,
  input wire logic selectN,
  input wire logic serialOutEnN,
  input wire logic bridgeOn,
  input wire logic shutoffInput,
  input wire logic currentClampFlag,
  input wire logic [7:0] faultStatus,
  input wire logic priorFrameError
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  sequence frameEnd;
    $rose(selectN);
  endsequence
  sequence inFrame;
    !selectN [*4];
  endsequence
  AST_DESEL: assert property (frameEnd |-> ##[1:5] serialOutEnN)
    else $error("output kept after deselect");
  AST_MODE: assert property (!modeSelectSupply [*5] |-> serialOutEnN)
    else $error("output driven in supply reset");
  AST_ADDR: assert property ($fell(selectN) |-> serialOutEnN [*8])
    else $error("output driven in address phase");
  AST_SHUT: assert property (shutoffInput [*5] |-> serialOutEnN)
    else $error("output driven while shut off");
  AST_ACTIVE: assert property (
    ($stable(bridgeOn) && $stable(shutoffInput)) [*8]
    |-> faultStatus[7] == (bridgeOn && !shutoffInput))
    else $error("active bit wrong");
  AST_CLAMP: assert property (
    currentClampFlag [*4] |-> ##[0:4] !faultStatus[4])
    else $error("clamp flag not captured");
  AST_NOSET: assert property (
    inFrame |=> (faultStatus[6:4] & ~$past(faultStatus[6:4])) == 3'h0)
    else $error("flag cleared inside a frame");
  AST_ERRHOLD: assert property (
    inFrame |=> $stable(priorFrameError))
    else $error("error flag moved inside a frame");
endmodule : hbd_spi_diag_sva
bind hbd_spi_diag hbd_spi_diag_sva u_sva (.core_clk(core_clk),
  .nrst(nrst), .modeSelectSupply(modeSelectSupply),
  .selectN(selectN), .serialOutEnN(serialOutEnN), .bridgeOn(bridgeOn),
  .shutoffInput(shutoffInput), .currentClampFlag(currentClampFlag),
  .faultStatus(faultStatus), .priorFrameError(priorFrameError));
`default_nettype wire

/* test/hbd_spi_master.sv */
// Purpose: Serial master model for the diagnostic port
// Assumes: linkClk free running, 64 ns period
// Notes: Half bit is two link ticks, so 256 ns a bit
`timescale 1ns/1ps
`default_nettype none
module hbd_spi_master (
  input wire logic linkClk,
  input wire logic serialOut,
  input wire logic serialOutEnN,
  output var logic sclk,
  output var logic selectN,
  output var logic serialIn
);
  initial begin
    sclk = 1'b0;
    selectN = 1'b1;
    serialIn = 1'b0;
  end
  // Clock idles low and stands still between frames
  task automatic xfer(input logic [15:0] tx, input int n,
      output logic [15:0] rx, output logic [15:0] drv);
    rx = 16'h0;
    drv = 16'h0;
    @(posedge linkClk);
    selectN <= 1'b0;
    repeat (4) @(posedge linkClk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      serialIn <= (i < 16) ? tx[15 - i] : 1'b0;
      repeat (2) @(posedge linkClk);
      if (i < 16) begin
        rx[15 - i] = serialOut;
        drv[15 - i] = !serialOutEnN;
      end
      sclk <= 1'b0;
      repeat (2) @(posedge linkClk);
    end
    @(posedge linkClk);
    selectN <= 1'b1;
    // Released line shows the inverse, not a stale bit
    serialIn <= !serialIn;
  endtask : xfer
endmodule : hbd_spi_master
`default_nettype wire

/* test/hbd_spi_diag_tb_top.sv */
// Purpose: Self-checking bench for hbd_spi_diag
// Assumes: Access time shortened to 60 cycles
// Notes: Read data may lag a frame, so reads go in pairs
`timescale 1ns/1ps
`default_nettype none
module hbd_spi_diag_tb_top
  import hbd_pkg::*;
;
  localparam logic [7:0] ID = 8'h3B; // Arbitrary value
  localparam logic [7:0] REV = 8'h16; // Arbitrary value
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic nrst = 1'b0;
  logic modeSel = 1'b1;
  logic bridgeOn = 1'b1;
  logic shutoff = 1'b0;
  logic [3:0] codes = 4'hF;
  logic [2:0] evts = 3'h0;
  logic sclk, selectN, serialIn, serialOut, serialOutEnN, priorFrameError;
  logic [7:0] faultStatus;
  logic [15:0] rx, drv;
  logic [5:0] op;
  logic [5:0] ops [3] = '{HBD_OP_IDENT, HBD_OP_REV, HBD_OP_FAULT};
  int dats [3] = '{ID, REV, 255};
  int n_errors = 0;
  int checked = 0;
  integer seed = 32'hD329BE5C;
  always #5 core_clk = ~core_clk;
  initial #3.3 forever #32 linkClk = ~linkClk;
  hbd_spi_diag #(.DEVICE_ID(ID), .SOFTWARE_REV(REV[7:4]),
    .MASK_REV(REV[3:0]), .ACCESS_CYC(60)) DUT (
    .core_clk(core_clk), .nrst(nrst), .clkEn(1'b1),
    .modeSelectSupply(modeSel), .sclk(sclk), .selectN(selectN),
    .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEnN(serialOutEnN), .bridgeOn(bridgeOn),
    .shutoffInput(shutoff), .out1FaultCodeHi(codes[1]),
    .out1FaultCodeLo(codes[0]), .out2FaultCodeHi(codes[3]),
    .out2FaultCodeLo(codes[2]), .currentClampFlag(evts[0]),
    .thermalDerateFlag(evts[1]), .overheatFlag(evts[2]),
    .faultStatus(faultStatus), .priorFrameError(priorFrameError));
  hbd_spi_master u_master (.linkClk(linkClk), .serialOut(serialOut),
    .serialOutEnN(serialOutEnN), .sclk(sclk), .selectN(selectN),
    .serialIn(serialIn));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  // Negative flag or dat skips that compare
  task automatic frame(input logic [1:0] adr, input logic [5:0] opc,
      input int n, input int flag, input int dat, input int gap);
    u_master.xfer({adr, opc, 8'($random(seed))}, n, rx, drv);
    if (adr != 2'h0) check(drv, 16'h0);
    else check(drv, (n < 16) ? 16'h3FFE : 16'h3FFF);
    if (adr == 2'h0) check(16'(rx[13:9]), 16'h15);
    if (flag >= 0) check(16'(rx[8]), 16'(flag));
    if (flag >= 0) check(16'(priorFrameError), 16'(flag));
    if (dat >= 0) check(16'(rx[7:0]), 16'(dat));
    cyc(gap);
  endtask : frame
  task automatic tally_and_finish;
    $display("checked %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #900000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    cyc(10);
    frame(2'h0, HBD_OP_IDENT, 16, 1, -1, 80);
    for (int i = 0; i < 6; i++) begin
      frame(2'h0, ops[i / 2], 16, (i > 0) ? 0 : -1,
        (i % 2) ? dats[i / 2] : -1, 80);
    end
    $display("end reads");
    for (int i = 0; i < 4; i++) begin
      op = 6'($random(seed)) | 6'h30;
      frame(2'h0, op, 16, (i > 0) ? 1 : 0, 255, 80);
    end
    frame(2'h0, HBD_OP_IDENT, 16, 1, -1, 80);
    $display("end unused codes");
    for (int n = 15; n <= 17; n += 2) begin
      frame(2'h0, HBD_OP_IDENT, n, 0, -1, 80);
      frame(2'h0, HBD_OP_IDENT, 16, 1, -1, 80);
      frame(2'h0, HBD_OP_IDENT, 16, (n > 16) ? 1 : 0, -1, 80);
    end
    $display("end clock counts");
    for (int a = 1; a < 4; a++) begin
      frame(2'(a), HBD_OP_FAULT, 16, -1, -1, 80);
    end
    frame(2'h0, HBD_OP_IDENT, 16, -1, -1, 80);
    frame(2'h0, HBD_OP_IDENT, 16, 0, -1, 0);
    frame(2'h0, HBD_OP_IDENT, 16, 0, -1, 80);
    frame(2'h0, HBD_OP_IDENT, 16, 1, -1, 80);
    $display("end address and early");
    evts[0] = 1'b1;
    cyc(4);
    evts[0] = 1'b0;
    modeSel = 1'b0;
    cyc(10);
    modeSel = 1'b1;
    cyc(10);
    check(16'(faultStatus), 16'hFF);
    frame(2'h0, HBD_OP_IDENT, 16, 1, -1, 80);
    for (int b = 0; b < 3; b++) begin
      evts[b] = 1'b1;
      cyc(4);
      evts[b] = 1'b0;
      cyc(6);
      check(16'(faultStatus[6:4]), 16'(3'(3'h7 << (b + 1))));
    end
    frame(2'h0, HBD_OP_FAULT, 15, -1, -1, 80);
    check(16'(faultStatus[6:4]), 16'h0);
    frame(2'h0, HBD_OP_FAULT, 16, 1, -1, 80);
    check(16'(faultStatus), 16'hFF);
    for (int k = 0; k < 3; k++) begin
      codes = (k == 0) ? 4'h0 : 4'($random(seed));
      cyc(4);
      frame(2'h0, HBD_OP_FAULT, 16, 0, -1, 80);
      check(16'(faultStatus[3:0]), 16'(codes));
    end
    codes = 4'hF;
    $display("end fault register");
    for (int c = 0; c < 4; c++) begin
      {bridgeOn, shutoff} = 2'(c);
      cyc(12);
      check(16'(faultStatus[7]), 16'(c == 2));
    end
    {bridgeOn, shutoff} = 2'h2;
    $display("end active bit");
    tally_and_finish();
  end
endmodule : hbd_spi_diag_tb_top
`default_nettype wire
